// ---- hw/host_microprocessor_port.sv ----
// Purpose: parallel host port onto a 32-word register set, plus APB side access
// Assumes: host pins synchronous to pclk; straps stable from reset onward
// Notes:   host writes commit on the trailing edge of the strobe
`timescale 1ns/10ps
// Operation
// R1: access only while chip select is low
// R2: separate strobes select read or write
// R3: drive read data during strobe; take write data
// R4: direction line decides read or write
// R5: latch transparent on ale high, holds after
// R6: ale level selects the bus style
// R7: width strap low 8 bit, high 16
// R8: irq push-pull either polarity or open-drain
// R9: irq asserted while a request is pending
// R10: board ties address to data in mux mode
// R11: reset returns all state to defaults
// R12: in reset irq and data bus released
module host_microprocessor_port
    import host_port_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // host bus control
    input  wire logic              chip_select_n,
    input  wire logic              read_n,
    input  wire logic              write_n,
    input  wire logic              ale,
    input  wire logic              wide_bus_select,
    // host address and data
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic      [1:0]        data_oe,
    // interrupt pin
    output logic                   interrupt_request_out_o,
    output logic                   interrupt_request_out_oe
);
    // in data-strobe style the read strobe pin carries transfer_strobe_n
    // and the write strobe pin the direction line (high = read)
    logic                   transfer_strobe_n;
    logic                   dir_read;
    assign transfer_strobe_n = read_n;
    assign dir_read          = write_n;

    // ==========================================================
    // register storage
    logic [DATA_W-1:0] regs [REG_WORDS];
    logic [1:0]        ctrl;
    logic [1:0]        next_ctrl;
    logic              pending;
    logic              next_pending;

    // ==========================================================
    // bus style, mode and width detection
    logic ale_q;
    logic sep_style;
    logic mux_mode;
    logic wide;
    logic strap_taken;
    logic next_sep_style;
    logic next_mux_mode;
    logic next_wide;

    always_comb begin
        // ale seen high means separate strobes; a fall means it is pulsed, so multiplexed
        next_sep_style = sep_style | ale; // R6
        next_mux_mode  = mux_mode | (ale_q & ~ale); // R5
        // strap caught once, at the first edge after release
        next_wide      = strap_taken ? wide : wide_bus_select; // R7
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_q       <= 1'b0; // R11
            sep_style   <= 1'b0;
            mux_mode    <= 1'b0;
            wide        <= 1'b0;
            strap_taken <= 1'b0;
        end else begin
            ale_q       <= ale;
            sep_style   <= next_sep_style;
            mux_mode    <= next_mux_mode;
            wide        <= next_wide;
            strap_taken <= 1'b1;
        end
    end

    // ==========================================================
    // address path
    logic [ADDR_W-1:0] latched_addr;
    logic [ADDR_W-1:0] eff_addr;

    // board wires the address pins onto the low data lines in mux mode
    addr_latch u_addr_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .ale     (ale),
        .bus_in  (data_i[ADDR_W-1:0]), // R10
        .addr    (latched_addr)
    );

    assign eff_addr = mux_mode ? latched_addr : host_addr; // R5

    // ==========================================================
    // host access engine
    host_state_t       hstate;
    host_state_t       next_hstate;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] next_acc_addr;
    logic              acc_read;
    logic              next_acc_read;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] next_data_o;
    logic [1:0]        next_data_oe;
    logic              strobe_on;
    logic              strobe_read;
    logic              host_we;

    always_comb begin
        if (sep_style) begin
            strobe_on   = ~chip_select_n & (~read_n | ~write_n); // R1 R2
            strobe_read = ~read_n; // R2
        end else begin
            strobe_on   = ~chip_select_n & ~transfer_strobe_n; // R1 R3
            strobe_read = dir_read; // R4
        end
    end

    always_comb begin
        next_hstate   = hstate;
        next_acc_addr = acc_addr;
        next_acc_read = acc_read;
        next_wdata    = wdata;
        next_data_o   = data_o;
        next_data_oe  = 2'h0;
        host_we       = 1'b0;
        case (hstate)
            HS_IDLE: begin
                if (strobe_on) begin
                    next_hstate   = HS_ACCESS;
                    next_acc_addr = eff_addr;
                    next_acc_read = strobe_read;
                    next_wdata    = data_i;
                end
            end
            HS_ACCESS: begin
                if (strobe_on) begin
                    next_wdata = data_i;
                    if (acc_read) begin
                        next_data_o  = wide ? regs[acc_addr] : {8'h00, regs[acc_addr][7:0]};
                        next_data_oe = {wide, 1'b1}; // R3 R7
                    end
                end else begin
                    // commit with the last data seen while the strobe was on
                    host_we     = ~acc_read; // R2 R3
                    next_hstate = HS_IDLE;
                end
            end
            default: begin
                next_hstate = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate   <= HS_IDLE; // R11
            acc_addr <= '0;
            acc_read <= 1'b0;
            wdata    <= '0;
            data_o   <= '0;
            data_oe  <= 2'h0; // R12
        end else begin
            hstate   <= next_hstate;
            acc_addr <= next_acc_addr;
            acc_read <= next_acc_read;
            wdata    <= next_wdata;
            data_o   <= next_data_o;
            data_oe  <= next_data_oe;
        end
    end

    // ==========================================================
    // apb slave
    logic        apb_setup;
    logic        apb_commit;
    logic        apb_we_reg;
    logic [4:0]  apb_idx;
    logic        in_regfile;
    logic        mapped;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        raise;

    assign apb_setup  = psel & ~penable;
    assign apb_commit = psel & penable & pready;
    assign in_regfile = (paddr[7] == OFF_REGFILE[7]) & (paddr[1:0] == 2'h0);
    assign apb_idx    = paddr[6:2];
    assign apb_we_reg = apb_commit & pwrite & in_regfile & ~pslverr;
    assign raise      = apb_commit & pwrite & (paddr == OFF_RAISE) & pwdata[RAISE_SET];

    always_comb begin
        mapped      = in_regfile | (paddr == OFF_CTRL) | (paddr == OFF_STATUS)
                    | (paddr == OFF_RAISE);
        next_prdata = 32'h0000_0000;
        if (in_regfile) begin
            next_prdata = {16'h0000, regs[apb_idx]};
        end else if (paddr == OFF_CTRL) begin
            next_prdata = {30'h0000_0000, ctrl};
        end else if (paddr == OFF_STATUS) begin
            next_prdata[ST_SEP_STYLE] = sep_style;
            next_prdata[ST_MUX_MODE]  = mux_mode;
            next_prdata[ST_WIDE]      = wide;
            next_prdata[ST_PENDING]   = pending;
            next_prdata[ST_HOST_BUSY] = (hstate == HS_ACCESS);
        end
        // answer is prepared during setup, so pready rises in the access cycle
        next_pready  = apb_setup;
        next_pslverr = apb_setup & ~mapped;
        if (!apb_setup) begin
            next_prdata = prdata;
        end
        next_ctrl = ctrl;
        if (apb_commit & pwrite & (paddr == OFF_CTRL)) begin
            next_ctrl = pwdata[1:0]; // R8
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ctrl    <= CTRL_RESET; // R11
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            ctrl    <= next_ctrl;
        end
    end

    // ==========================================================
    // register set, host write wins over apb on the same word
    genvar gi;
    generate
        for (gi = 0; gi < REG_WORDS; gi++) begin : g_reg
            logic [DATA_W-1:0] next_word;
            always_comb begin
                next_word = regs[gi];
                if (apb_we_reg && (apb_idx == 5'(gi))) begin
                    next_word = pwdata[DATA_W-1:0];
                end
                if (host_we && (acc_addr == 5'(gi))) begin
                    // narrow bus leaves the upper byte untouched
                    next_word = wide ? wdata : {regs[gi][15:8], wdata[7:0]}; // R7
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs[gi] <= REG_RESET; // R11
                end else begin
                    regs[gi] <= next_word;
                end
            end
        end
    endgenerate

    // ==========================================================
    // attention request: set from apb, cleared by host writing a one to bit 0 of the attention word
    logic host_ack;
    assign host_ack = host_we & (acc_addr == ATTN_ADDR) & wdata[0];

    always_comb begin
        // a raise in the same cycle as the acknowledge is kept
        next_pending = raise | (pending & ~host_ack); // R9
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0; // R11
        end else begin
            pending <= next_pending;
        end
    end

    // ==========================================================
    // interrupt pin
    irq_if irq ();
    assign irq.pending     = pending;
    assign irq.open_drain  = ctrl[CTRL_OPEN_DRAIN];
    assign irq.active_high = ctrl[CTRL_ACTIVE_HIGH];

    irq_driver u_irq_driver (
        .pclk    (pclk),
        .presetn (presetn),
        .irq     (irq)
    );

    assign interrupt_request_out_o  = irq.pin_o;
    assign interrupt_request_out_oe = irq.pin_oe;
endmodule

// ---- include/host_port_pkg.sv ----
// Purpose: shared constants for the host microprocessor port
// Assumes: APB register side at 32-bit words, host register set of 32 16-bit words
// Notes:   all offsets are byte addresses on APB
package host_port_pkg;
    // ==========================================================
    // apb register map
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_RAISE    = 8'h08;
    localparam logic [7:0]  OFF_REGFILE  = 8'h80;
    // ==========================================================
    // field positions
    localparam int CTRL_OPEN_DRAIN  = 0;
    localparam int CTRL_ACTIVE_HIGH = 1;
    localparam int ST_SEP_STYLE     = 0;
    localparam int ST_MUX_MODE      = 1;
    localparam int ST_WIDE          = 2;
    localparam int ST_PENDING       = 3;
    localparam int ST_HOST_BUSY     = 4;
    localparam int RAISE_SET        = 0;
    // ==========================================================
    // reset values and sizes
    localparam logic [1:0]  CTRL_RESET   = 2'h0;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [4:0]  ATTN_ADDR    = 5'h1F;
    localparam int          REG_WORDS    = 32;
    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 16;
    typedef enum logic [0:0] {HS_IDLE, HS_ACCESS} host_state_t;
endpackage

// ---- include/irq_if.sv ----
// Purpose: carries the interrupt request and its drive setup to the pin driver
// Assumes: all signals synchronous to pclk
// Notes:   pin_o and pin_oe come from flip-flops in the driver
`timescale 1ns/10ps
interface irq_if;
    logic pending;
    logic open_drain;
    logic active_high;
    logic pin_o;
    logic pin_oe;
    modport ctrl (output pending, output open_drain, output active_high,
                  input pin_o, input pin_oe);
    modport drv  (input pending, input open_drain, input active_high,
                  output pin_o, output pin_oe);
endinterface

// ---- hw/addr_latch.sv ----
// Purpose: on-chip address latch for multiplexed host bus
// Assumes: ale and bus lines synchronous to pclk
// Notes:   transparent while ale high, holds value after its fall
`timescale 1ns/10ps
module addr_latch
    import host_port_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // latch control and data
    input  wire logic              ale,
    input  wire logic [ADDR_W-1:0] bus_in,
    output logic      [ADDR_W-1:0] addr
);
    logic [ADDR_W-1:0] held;
    logic [ADDR_W-1:0] next_held;

    // ==========================================================
    // latch
    always_comb begin
        next_held = ale ? bus_in : held; // R5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= '0;
        end else begin
            held <= next_held;
        end
    end

    // passes through while open, so an access right after the fall sees the address
    assign addr = ale ? bus_in : held; // R5
endmodule

// ---- hw/irq_driver.sv ----
// Purpose: drives the interrupt request pin as push-pull or open-drain
// Assumes: settings from the control register are stable between requests
// Notes:   pin released (oe low) during reset
`timescale 1ns/10ps
module irq_driver (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // request and pin
    irq_if.drv        irq
);
    logic next_o;
    logic next_oe;
    logic o_q;
    logic oe_q;

    // ==========================================================
    // drive type and polarity
    always_comb begin
        if (irq.open_drain) begin
            // shared line: only ever pull low, never drive high
            next_o  = 1'b0; // R8
            next_oe = irq.pending; // R9
        end else begin
            next_o  = irq.active_high ? irq.pending : ~irq.pending; // R8 R9
            next_oe = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            o_q  <= 1'b0; // R12
            oe_q <= 1'b0; // R12
        end else begin
            o_q  <= next_o;
            oe_q <= next_oe;
        end
    end

    assign irq.pin_o  = o_q;
    assign irq.pin_oe = oe_q;
endmodule

// ---- tb/host_port_properties.sv ----
// Purpose: pin and apb checks for the host port
// Assumes: one clock domain, presetn async active low
// Notes:   irq drive type is tracked from apb writes to ctrl
`timescale 1ns/10ps
module host_port_properties
    import host_port_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // host pins
    input wire logic        chip_select_n,
    input wire logic        read_n,
    input wire logic        write_n,
    input wire logic        wide_bus_select,
    input wire logic [15:0] data_o,
    input wire logic [1:0]  data_oe,
    input wire logic        interrupt_request_out_o,
    input wire logic        interrupt_request_out_oe
);
    // ==========
    // ctrl shadow
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic       apb_wr;
    logic       raise;
    assign apb_wr = psel && penable && pready && pwrite;
    assign raise = apb_wr && paddr == OFF_RAISE && pwdata[RAISE_SET];
    always_comb begin
        next_ctrl = ctrl;
        if (apb_wr && paddr == OFF_CTRL)
            next_ctrl = pwdata[1:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl <= CTRL_RESET;
        else
            ctrl <= next_ctrl;
    end
    // ==========
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_take;
        $fell(read_n) && !chip_select_n && write_n;
    endsequence
    sequence rd_drive;
        ##2 data_oe != 2'h0;
    endsequence
    AST_RST_QUIET:
        assert property ($rose(presetn) |-> data_oe == 2'h0 && !interrupt_request_out_oe)
        else $error("pins driven at reset release");
    AST_CS_GATE:
        assert property (chip_select_n [*3] |-> data_oe == 2'h0)
        else $error("data bus driven while deselected");
    AST_RD_SRC:
        assert property (data_oe != 2'h0 |-> !$past(chip_select_n) && !$past(read_n))
        else $error("data bus driven without read strobe");
    AST_RD_LAT:
        assert property (rd_take |-> rd_drive)
        else $error("read data not driven two cycles after strobe");
    AST_WR_QUIET:
        assert property ((!chip_select_n && !write_n) [*2] |-> data_oe == 2'h0)
        else $error("data bus driven in a write");
    AST_WIDTH:
        assert property (data_oe != 2'h0 |-> data_oe == (wide_bus_select ? 2'h3 : 2'h1)
            && (wide_bus_select || data_o[15:8] == 8'h00))
        else $error("driven lanes do not match width strap");
    AST_OD_LOW:
        assert property (ctrl[CTRL_OPEN_DRAIN] [*3]
            |-> !(interrupt_request_out_oe && interrupt_request_out_o))
        else $error("open drain pin driven high");
    AST_PP_DRIVE:
        assert property (!ctrl[CTRL_OPEN_DRAIN] [*3] |-> interrupt_request_out_oe)
        else $error("push pull pin not driven");
    AST_IRQ_RAISE:
        assert property (raise && !ctrl[CTRL_OPEN_DRAIN]
            |-> ##[1:3] interrupt_request_out_o == ctrl[CTRL_ACTIVE_HIGH])
        else $error("request not shown at configured polarity");
    AST_APB_ANSWER:
        assert property (psel && !penable |=> pready)
        else $error("apb answer late");
endmodule

bind host_microprocessor_port host_port_properties host_port_properties_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .chip_select_n,
    .read_n, .write_n, .wide_bus_select, .data_o, .data_oe, .interrupt_request_out_o,
    .interrupt_request_out_oe
);

// ---- tb/host_bus_model.sv ----
// Purpose: behavioural host processor on the parallel bus
// Assumes: style chosen by the bench before reset release
// Notes:   released data lanes toggle, since nothing pulls them
`timescale 1ns/10ps
module host_bus_model (
    // clock and style
    input  wire logic        pclk,
    input  wire logic        strobe_style,
    input  wire logic        ale_tied,
    // bus control
    output logic             chip_select_n,
    output logic             read_n,
    output logic             write_n,
    output logic             ale,
    // address and data
    output logic      [4:0]  host_addr,
    output logic      [15:0] data_i,
    input  wire logic [15:0] data_o,
    input  wire logic [1:0]  data_oe
);
    logic [15:0] host_d = 16'h0000;
    logic [15:0] last_bus = 16'h0000;
    logic        host_oe = 1'b0;
    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        ale = 1'b0;
        host_addr = 5'h00;
    end
    // ==========
    // bus resolution
    always_comb begin
        data_i = host_oe ? host_d : ~last_bus;
        if (data_oe[0])
            data_i[7:0] = data_o[7:0];
        if (data_oe[1])
            data_i[15:8] = data_o[15:8];
    end
    always @(posedge pclk)
        last_bus <= data_i;
    // ==========
    // one transfer, strobe held four cycles
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] wd,
                        input logic csn, output logic [15:0] rd);
        // address pins carry junk in mux mode so only the latch can deliver it
        host_addr <= (strobe_style || ale_tied) ? a : ~a;
        if (ale_tied && !ale) begin
            // latch enable held high from here on: separate strobes, no muxing
            ale <= 1'b1;
            @(posedge pclk);
        end
        if (!strobe_style && !ale_tied) begin
            ale     <= 1'b1;
            host_oe <= 1'b1;
            host_d  <= {11'h000, a};
            @(posedge pclk);
            ale <= 1'b0;
            @(posedge pclk);
        end
        host_oe       <= wr;
        host_d        <= wd;
        chip_select_n <= csn;
        read_n        <= strobe_style ? 1'b0 : wr;
        write_n       <= ~wr;
        repeat (4) @(posedge pclk);
        rd = data_i;
        chip_select_n <= 1'b1;
        read_n        <= 1'b1;
        write_n       <= 1'b1;
        host_oe       <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
endmodule

// ---- tb/host_microprocessor_port_tb.sv ----
// Purpose: self-checking bench for the host port
// Assumes: 200 MHz pclk; host model as bus partner
// Notes:   later resets move to narrow data-strobe, then wide demultiplexed style
`timescale 1ns/10ps
module host_microprocessor_port_tb
    import host_port_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        chip_select_n;
    logic        read_n;
    logic        write_n;
    logic        ale;
    logic        wide_bus_select = 1'b1;
    logic        strobe_style = 1'b0;
    logic        ale_tied = 1'b0;
    logic [4:0]  host_addr;
    logic [15:0] data_i;
    logic [15:0] data_o;
    logic [1:0]  data_oe;
    logic        interrupt_request_out_o;
    logic        interrupt_request_out_oe;
    int          n_fail = 0;
    int          check_count = 0;
    // {oe,o} when pending, then when idle, per ctrl value
    localparam logic [3:0] IRQ_EXP [3] = '{4'hB, 4'h8, 4'hE};
    always #2.5 pclk = ~pclk;
    host_microprocessor_port host_microprocessor_port_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .chip_select_n, .read_n, .write_n, .ale, .wide_bus_select, .host_addr,
        .data_i, .data_o, .data_oe, .interrupt_request_out_o, .interrupt_request_out_oe
    );
    host_bus_model host_bus_model_i (
        .pclk, .strobe_style, .ale_tied, .chip_select_n, .read_n, .write_n, .ale, .host_addr,
        .data_i, .data_o, .data_oe
    );
    // ==========
    // tasks
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        chk(n < 50, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic hr(input logic [4:0] a, input logic [15:0] m, input logic [15:0] x);
        logic [15:0] d;
        host_bus_model_i.xfer(1'b0, a, 16'h0000, 1'b0, d);
        chk({16'h0, d & m}, {16'h0, x});
    endtask
    task automatic hw(input logic [4:0] a, input logic [15:0] v, input logic csn);
        logic [15:0] d;
        host_bus_model_i.xfer(1'b1, a, v, csn, d);
    endtask
    task automatic do_reset(input logic w, input logic sty);
        presetn         <= 1'b0;
        wide_bus_select <= w;
        strobe_style    <= sty;
        repeat (12) @(posedge pclk);
        chk({30'h0, data_oe, interrupt_request_out_oe}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    // ==========
    // tests
    initial begin
        do_reset(1'b1, 1'b0);
        wr(OFF_REGFILE + 8'h0C, 32'h1234_ABCD);
        hr(5'h03, 16'hFFFF, 16'hABCD);
        hw(5'h05, 16'h5A3C, 1'b0);
        rd(OFF_REGFILE + 8'h14, 32'h0000_5A3C, 1'b0);
        hw(5'h06, 16'h7E81, 1'b1);
        rd(OFF_REGFILE + 8'h18, 32'h0, 1'b0);
        rd(OFF_STATUS, 32'h7, 1'b0);
        rd(8'h0C, 32'h0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTRL, 32'(i));
            wr(OFF_RAISE, 32'h1);
            repeat (3) @(posedge pclk);
            chk({30'h0, interrupt_request_out_oe, interrupt_request_out_o},
                {30'h0, IRQ_EXP[i][3:2]});
            hw(ATTN_ADDR, 16'h0001, 1'b0);
            repeat (3) @(posedge pclk);
            chk({30'h0, interrupt_request_out_oe, interrupt_request_out_o},
                {30'h0, IRQ_EXP[i][1:0]});
        end
        do_reset(1'b0, 1'b1);
        rd(OFF_REGFILE + 8'h14, 32'h0, 1'b0);
        wr(OFF_REGFILE + 8'h08, 32'h0000_BEEF);
        hr(5'h02, 16'h00FF, 16'h00EF);
        hw(5'h04, 16'hC3A5, 1'b0);
        rd(OFF_REGFILE + 8'h10, 32'h0000_00A5, 1'b0);
        rd(OFF_STATUS, 32'h0, 1'b0);
        ale_tied <= 1'b1;
        do_reset(1'b1, 1'b0);
        hw(5'h07, 16'h9D62, 1'b0);
        rd(OFF_REGFILE + 8'h1C, 32'h0000_9D62, 1'b0);
        hr(5'h07, 16'hFFFF, 16'h9D62);
        rd(OFF_STATUS, 32'h5, 1'b0);
        close_out;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        $display("Error at %0t: run did not finish", $time);
        close_out;
    end
endmodule
